// [rtl/spr_bank.sv]
// Register bank: port 1 and 2 VLAN priority remap, learn-discard counters, irq gate.
// Assumes APB master on pclk; frame and event inputs are synchronous to pclk.
`timescale 1ns/1ps

// Overview of operation
// [R1] Ports 1 and 2 each hold eight 3-bit remap entries, entry n at 3n+2:3n.
// [R2] Output queue priority is the remapped value from the receiving port's table.
// [R3] After reset each remap entry equals its own index.
// [R4] Remap bits 31:24 are read-only zero; writes there do nothing.
// [R5] Each of ports 0,1,2 has a 32-bit counter of learn discards.
// [R6] Reading a counter returns its value and clears it; reset value zero.
// [R7] Counters saturate at all ones and never wrap.
// [R8] Port 0 counter counts discards from the host MAC port.
// [R9] While gate bit 0 is set every switch interrupt is suppressed.
// [R10] The gate masks only the output; pending bits keep recording.
// [R11] Gate bit resets to one; bits 31:1 read-only zero.
// [R12] Pending register holds buffered status, all sources under the single gate.
// [R13] A discard coinciding with the read-clear leaves the counter at one.
// [R14] Interrupt output is high only with a pending bit set and gate clear.
module spr_bank
(
  // Clock and reset
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [spr_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Ingress priority lookup
  input  wire spr_pkg::spr_prio_s          rx_prio,
  output spr_pkg::spr_prio_s               queue_prio,
  // Switch engine events
  input  wire logic [spr_pkg::N_PORT-1:0]  learn_drop,
  input  wire logic [spr_pkg::PEND_W-1:0]  pend_event,
  output logic                             switch_irq
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [spr_pkg::REMAP_W-1:0] remap1_r;
  logic [spr_pkg::REMAP_W-1:0] remap2_r;
  logic [31:0]                 cnt_r [spr_pkg::N_PORT];
  logic                        gate_r;
  logic [spr_pkg::PEND_W-1:0]  pend_r;
  logic [31:0]                 prdata_r;
  logic                        pready_r;
  logic                        pslverr_r;
  spr_pkg::spr_prio_s          queue_r;
  logic                        irq_r;

  logic [13:0]                 idx;
  logic                        setup;
  logic                        wr_acc;
  logic                        rd_setup;
  logic [31:0]                 rd_nxt;
  logic                        hit_nxt;
  logic [spr_pkg::N_PORT-1:0]  clr_cnt;
  logic                        clr_pend;
  logic                        wr_remap1;
  logic                        wr_remap2;
  logic                        wr_gate;

  assign idx      = paddr[spr_pkg::ADDR_W-1:spr_pkg::IDX_LSB];
  assign setup    = psel & ~penable;
  assign wr_acc   = psel & penable & pready_r & pwrite;
  assign rd_setup = setup & ~pwrite;

  // Pick entry n of a remap table
  function automatic logic [spr_pkg::PRIO_W-1:0] remap_pick(
    input logic [spr_pkg::REMAP_W-1:0] tbl,
    input logic [spr_pkg::PRIO_W-1:0]  prio
  );
    remap_pick = tbl[prio*spr_pkg::PRIO_W +: spr_pkg::PRIO_W]; // see [R1]
  endfunction

  // Saturating add of one discard event
  function automatic logic [31:0] sat_inc(
    input logic [31:0] cnt,
    input logic        ev
  );
    if (ev && cnt != spr_pkg::CNT_MAX)
    begin
      sat_inc = cnt + spr_pkg::CNT_ONE;
    end
    else
    begin
      sat_inc = cnt; // see [R7]
    end
  endfunction

  // ****************************************************************
  // Read decode
  // ****************************************************************
  always_comb
  begin
    rd_nxt   = spr_pkg::CNT_ZERO;
    hit_nxt  = 1'b1;
    clr_cnt  = '0;
    clr_pend = 1'b0;
    if (idx == spr_pkg::IDX_P1_REMAP)
    begin
      rd_nxt = {8'h00, remap1_r}; // see [R4]
    end
    else if (idx == spr_pkg::IDX_P2_REMAP)
    begin
      rd_nxt = {8'h00, remap2_r};
    end
    else if (idx == spr_pkg::IDX_P0_DROPCNT)
    begin
      rd_nxt     = cnt_r[0];
      clr_cnt[0] = rd_setup;
    end
    else if (idx == spr_pkg::IDX_P1_DROPCNT)
    begin
      rd_nxt     = cnt_r[1];
      clr_cnt[1] = rd_setup;
    end
    else if (idx == spr_pkg::IDX_P2_DROPCNT)
    begin
      rd_nxt     = cnt_r[2];
      clr_cnt[2] = rd_setup;
    end
    else if (idx == spr_pkg::IDX_IRQ_GATE)
    begin
      rd_nxt = {31'h0000_0000, gate_r}; // see [R11]
    end
    else if (idx == spr_pkg::IDX_IRQ_PEND)
    begin
      rd_nxt   = {17'h0_0000, pend_r};
      clr_pend = rd_setup;
    end
    else
    begin
      hit_nxt = 1'b0;
    end
  end

  // ****************************************************************
  // APB handshake: one wait-free access phase after each setup
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= setup;
      pslverr_r <= setup & ~hit_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_r <= spr_pkg::CNT_ZERO;
    end
    else if (rd_setup)
    begin
      // Snapshot at setup so the clear cannot race the returned value
      prdata_r <= rd_nxt; // see [R6]
    end
  end

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // Counters and pending are read-clear only, so a write there is dropped
  always_comb
  begin
    wr_remap1 = 1'b0;
    wr_remap2 = 1'b0;
    wr_gate   = 1'b0;
    if (idx == spr_pkg::IDX_P1_REMAP)
    begin
      wr_remap1 = wr_acc;
    end
    else if (idx == spr_pkg::IDX_P2_REMAP)
    begin
      wr_remap2 = wr_acc;
    end
    else if (idx == spr_pkg::IDX_IRQ_GATE)
    begin
      wr_gate = wr_acc;
    end
  end

  // ****************************************************************
  // Remap tables and gate
  // ****************************************************************
  // Only the low 24 bits are stored, so the reserved top byte cannot be set
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      remap1_r <= spr_pkg::REMAP_RESET; // see [R3]
    end
    else if (wr_remap1)
    begin
      remap1_r <= pwdata[spr_pkg::REMAP_W-1:0]; // see [R1] [R4]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      remap2_r <= spr_pkg::REMAP_RESET; // see [R3]
    end
    else if (wr_remap2)
    begin
      remap2_r <= pwdata[spr_pkg::REMAP_W-1:0]; // see [R1] [R4]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gate_r <= spr_pkg::GATE_RESET; // see [R11]
    end
    else if (wr_gate)
    begin
      gate_r <= pwdata[spr_pkg::GATE_BIT]; // see [R9]
    end
  end

  // ****************************************************************
  // Learn-discard counters
  // ****************************************************************
  // Index 0 is the host MAC port
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < spr_pkg::N_PORT; i++)
      begin
        cnt_r[i] <= spr_pkg::CNT_ZERO; // see [R6]
      end
    end
    else
    begin
      for (int i = 0; i < spr_pkg::N_PORT; i++)
      begin
        if (clr_cnt[i])
        begin
          // An event landing on the clear edge survives as a count of one
          cnt_r[i] <= learn_drop[i] ? spr_pkg::CNT_ONE : spr_pkg::CNT_ZERO; // see [R13] [R6]
        end
        else
        begin
          cnt_r[i] <= sat_inc(cnt_r[i], learn_drop[i]); // see [R5] [R8]
        end
      end
    end
  end

  // ****************************************************************
  // Pending status and interrupt gate
  // ****************************************************************
  // Pending records regardless of the gate; the gate acts on the output only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_r <= '0;
    end
    else if (clr_pend)
    begin
      pend_r <= pend_event; // see [R10] [R12]
    end
    else
    begin
      pend_r <= pend_r | pend_event; // see [R10]
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= (|pend_r) & ~gate_r; // see [R9] [R14] [R12]
    end
  end

  // ****************************************************************
  // Priority regeneration
  // ****************************************************************
  // Port 0 has no table here and passes its priority unchanged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      queue_r.valid <= 1'b0;
      queue_r.port  <= 2'd0;
    end
    else
    begin
      queue_r.valid <= rx_prio.valid;
      queue_r.port  <= rx_prio.port;
    end
  end

  // Table lookup costs one cycle; valid and port are delayed to match
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      queue_r.prio <= '0;
    end
    else
    begin
      if (rx_prio.port == 2'd1)
      begin
        queue_r.prio <= remap_pick(remap1_r, rx_prio.prio); // see [R2]
      end
      else if (rx_prio.port == 2'd2)
      begin
        queue_r.prio <= remap_pick(remap2_r, rx_prio.prio); // see [R2]
      end
      else
      begin
        queue_r.prio <= rx_prio.prio;
      end
    end
  end

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign queue_prio = queue_r;
  assign switch_irq = irq_r;

endmodule

// [shared/spr_pkg.sv]
// Package for the switch priority remap, learn-discard counter and irq gate bank.
// Assumes a 32-bit APB slave on a single 50 MHz clock; registers are word indexed.
package spr_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [13:0] IDX_P1_REMAP   = 14'h1856;
  localparam logic [13:0] IDX_P2_REMAP   = 14'h1857;
  localparam logic [13:0] IDX_P0_DROPCNT = 14'h1858;
  localparam logic [13:0] IDX_P1_DROPCNT = 14'h1859;
  localparam logic [13:0] IDX_P2_DROPCNT = 14'h185a;
  localparam logic [13:0] IDX_IRQ_GATE   = 14'h1880;
  localparam logic [13:0] IDX_IRQ_PEND   = 14'h1881;

  localparam int unsigned ADDR_W    = 16;
  localparam int unsigned IDX_LSB   = 2;
  localparam int unsigned PRIO_W    = 3;
  localparam int unsigned N_PRIO    = 8;
  localparam int unsigned REMAP_W   = PRIO_W * N_PRIO;
  localparam int unsigned N_PORT    = 3;
  localparam int unsigned PEND_W    = 15;

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [23:0] REMAP_RESET = 24'hfa_c688;
  localparam logic [31:0] CNT_ZERO    = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE     = 32'h0000_0001;
  localparam logic [31:0] CNT_MAX     = 32'hffff_ffff;
  localparam logic        GATE_RESET  = 1'b1;
  localparam int unsigned GATE_BIT    = 0;

  // Ingress priority lookup request and answer
  typedef struct packed {
    logic              valid;
    logic [1:0]        port;
    logic [PRIO_W-1:0] prio;
  } spr_prio_s;

endpackage

// [verification/spr_bank_chk.sv]
// Checker for spr_bank: APB read fields, lookup and irq relations at the ports.
// Assumes it is bound to every spr_bank instance on a single pclk domain.
`timescale 1ns/1ps
module spr_bank_chk
(
  // Clock, reset and APB
  input wire logic                       pclk,
  input wire logic                       presetn,
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pwrite,
  input wire logic [spr_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0]                pwdata,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  // Lookup and events
  input wire spr_pkg::spr_prio_s         rx_prio,
  input wire spr_pkg::spr_prio_s         queue_prio,
  input wire logic [spr_pkg::N_PORT-1:0] learn_drop,
  input wire logic                       switch_irq
);
  logic [13:0] idx;
  logic        acc;
  logic        set_c0;
  assign idx    = paddr[15:2];
  assign acc    = psel && penable && pready;
  assign set_c0 = psel && !penable && idx == spr_pkg::IDX_P0_DROPCNT;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****
  // Properties
  // ****
  sequence s_c0_pair(logic ev);
    set_c0 && learn_drop[0] == ev ##1 !learn_drop[0] ##1 set_c0;
  endsequence
  property p_q_valid;
    rx_prio.valid |=> queue_prio.valid;
  endproperty
  property p_q_port0;
    rx_prio.valid && rx_prio.port == 2'd0 |=> queue_prio.prio == $past(rx_prio.prio);
  endproperty
  property p_remap_rsvd;
    acc && !pwrite && (idx == spr_pkg::IDX_P1_REMAP || idx == spr_pkg::IDX_P2_REMAP)
      |-> prdata[31:24] == 8'h00;
  endproperty
  property p_gate_rsvd;
    acc && !pwrite && idx == spr_pkg::IDX_IRQ_GATE |-> prdata[31:1] == 31'h0;
  endproperty
  property p_cnt_clear;
    s_c0_pair(1'b0) |=> prdata == spr_pkg::CNT_ZERO;
  endproperty
  property p_cnt_keep;
    s_c0_pair(1'b1) |=> prdata == spr_pkg::CNT_ONE;
  endproperty
  property p_irq_gate;
    acc && pwrite && idx == spr_pkg::IDX_IRQ_GATE && pwdata[0] |=> ##1 !switch_irq;
  endproperty
  property p_irq_rst;
    $rose(presetn) |-> !switch_irq [*2];
  endproperty
  a_q_valid: assert property (p_q_valid) else $error("lookup valid lost");
  a_q_port0: assert property (p_q_port0) else $error("port0 prio altered");
  a_remap_rsvd: assert property (p_remap_rsvd) else $error("remap top bits set");
  a_gate_rsvd: assert property (p_gate_rsvd) else $error("gate top bits set");
  a_cnt_clear: assert property (p_cnt_clear) else $error("count not cleared");
  a_cnt_keep: assert property (p_cnt_keep) else $error("count event lost");
  a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
  a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
endmodule

bind spr_bank spr_bank_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .rx_prio(rx_prio), .queue_prio(queue_prio), .learn_drop(learn_drop),
  .switch_irq(switch_irq));

// [verification/spr_bank_tb.sv]
// Self-checking bench for spr_bank: registers over APB, lookup, counters, irq.
// Assumes spr_bank_chk is compiled alongside; seed fixed at 98.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h exp %h", $time, g, e); end end
module switch_prio_regen_learn_count_tb;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr, switch_irq, err;
  logic [15:0]        paddr;
  logic [31:0]        pwdata, prdata, rd, w;
  logic [2:0]         learn_drop, v;
  logic [14:0]        pend_event, v15;
  spr_pkg::spr_prio_s rx_prio, queue_prio;
  int                 seed, error_cnt, tests_run, cnt [3];
  spr_bank u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_prio(rx_prio), .queue_prio(queue_prio),
    .learn_drop(learn_drop), .pend_event(pend_event), .switch_irq(switch_irq));
  always #10 pclk = ~pclk;
  // ****
  // Tasks
  // ****
  task automatic results();
    $display("errors %0d of %0d checks", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Leaves psel high so a following call chains back to back
  task automatic apb(input logic wr, input logic [13:0] i, input logic [31:0] d, input logic ev);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {i, 2'b00};
    pwdata <= d;
    learn_drop <= {2'b00, ev};
    @(posedge pclk);
    penable <= 1'b1;
    learn_drop <= 3'b000;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      error_cnt++;
      results();
    end
    rd = prdata;
    err = pslverr;
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rchk(input logic [13:0] i, input logic [31:0] e);
    apb(1'b0, i, 32'h0, 1'b0);
    idle();
    `CHK(rd, e)
  endtask
  task automatic look(input logic [1:0] p, input logic [2:0] n, input logic [2:0] e);
    rx_prio <= '{1'b1, p, n};
    @(posedge pclk);
    #1;
    `CHK(queue_prio, {1'b1, p, e})
  endtask
  task automatic gate(input logic [31:0] d, input logic e);
    apb(1'b1, spr_pkg::IDX_IRQ_GATE, d, 1'b0);
    idle();
    repeat (2) @(posedge pclk);
    `CHK(switch_irq, e)
  endtask
  function automatic logic [31:0] ident();
    logic [31:0] t;
    t = '0;
    for (int n = 0; n < 8; n++)
      t[3*n+:3] = 3'(n);
    return t;
  endfunction
  // ****
  // Main sequence
  // ****
  initial
  begin
    seed = 98;
    error_cnt = 0;
    tests_run = 0;
    pclk = 0;
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rx_prio = '0;
    learn_drop = '0;
    pend_event = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rchk(spr_pkg::IDX_P1_REMAP, ident());
    rchk(spr_pkg::IDX_P2_REMAP, ident());
    for (int k = 0; k < 3; k++)
      rchk(spr_pkg::IDX_P0_DROPCNT + 14'(k), 32'h0000_0000);
    rchk(spr_pkg::IDX_IRQ_GATE, 32'h0000_0001);
    apb(1'b0, 14'h1870, 32'h0, 1'b0);
    idle();
    `CHK(err, 1'b1)
    for (int p = 1; p < 3; p++)
    begin
      w = $random(seed);
      apb(1'b1, spr_pkg::IDX_P1_REMAP + 14'(p - 1), w, 1'b0);
      idle();
      rchk(spr_pkg::IDX_P1_REMAP + 14'(p - 1), {8'h00, w[23:0]});
      for (int n = 0; n < 8; n++)
        look(2'(p), 3'(n), w[3*n+:3]);
    end
    for (int n = 0; n < 8; n++)
      look(2'd0, 3'(n), 3'(n));
    rx_prio <= '0;
    @(posedge pclk);
    cnt = '{0, 0, 0};
    repeat (6)
    begin
      v = 3'($random(seed));
      learn_drop <= v;
      for (int k = 0; k < 3; k++)
        cnt[k] += v[k];
      @(posedge pclk);
    end
    for (int k = 0; k < 3; k++)
      rchk(spr_pkg::IDX_P0_DROPCNT + 14'(k), cnt[k]);
    apb(1'b0, spr_pkg::IDX_P0_DROPCNT, 32'h0, 1'b0);
    apb(1'b0, spr_pkg::IDX_P0_DROPCNT, 32'h0, 1'b1);
    `CHK(rd, 32'h0000_0000)
    apb(1'b0, spr_pkg::IDX_P0_DROPCNT, 32'h0, 1'b0);
    `CHK(rd, 32'h0000_0001)
    idle();
    v15 = 15'($random(seed)) | 15'h0001;
    pend_event <= v15;
    @(posedge pclk);
    pend_event <= 15'h0000;
    repeat (3) @(posedge pclk);
    `CHK(switch_irq, 1'b0)
    w = $random(seed);
    gate({w[31:1], 1'b0}, 1'b1);
    rchk(spr_pkg::IDX_IRQ_GATE, 32'h0000_0000);
    gate(32'h0000_0001, 1'b0);
    gate(32'h0000_0000, 1'b1);
    rchk(spr_pkg::IDX_IRQ_PEND, {17'h0_0000, v15});
    repeat (2) @(posedge pclk);
    `CHK(switch_irq, 1'b0)
    results();
  end
endmodule
